//--- hdl/fps_pkg.sv
// Constants and types shared by both ends of the flash command sequencer.
// Assumes a single 100 MHz machine clock and an 8-bit data, 16-bit address CPU bus.
// Contract
// - Flash array ends at FFFF, size-dependent start
// - CPU avoids flash reads during program/erase
// - Programming routine runs from RAM
// - Status bits 7 and 6 read zero
// - Done flag sets when algorithm finishes
// - Interrupt when done flag and enable set
// - Write zero clears flag; RMW reads one
// - Busy blocks program/erase; read/reset still accepted during erase
// - Ready returns high when operation ends
// - Ready falls two cycles after command
// - Software writes zero to reserved bits
// - Write enable gates program/erase action
// - Three commands: read/reset, program, erase
// - Read/reset: single F0 or four cycles
// - Program: AA, 55, A0, then data
// - Chip erase: six-write sequence
// - Mismatched upper nibble blocks recognition until reset; code locks only on the program data write, erase writes 4-6 unchecked
// - Command writes ignored during automatic programming
// - Target read during algorithm returns timeout bit5
// - Read/reset state after power-on and termination
package fps_pkg;
    localparam logic [15:0] STATUS_ADDR    = 16'h0072;
    localparam logic [15:0] FLASH_END      = 16'hffff;
    localparam logic [15:0] FLASH_BASE_4K  = 16'hf000;
    localparam logic [15:0] FLASH_BASE_8K  = 16'he000;
    localparam logic [15:0] FLASH_BASE_16K = 16'hc000;
    // Status field positions
    localparam int BIT_DONE  = 5;
    localparam int BIT_RDY   = 4;
    localparam int BIT_DONE_IRQ_ENABLE = 2;
    localparam int BIT_WRE   = 1;
    localparam int BIT_TMO   = 5;
    // Command addresses (low 12 bits) and data
    localparam logic [11:0] CMD_ADDR_A = 12'haaa;
    localparam logic [11:0] CMD_ADDR_5 = 12'h554;
    localparam logic [7:0]  CMD_UNLK1  = 8'haa;
    localparam logic [7:0]  CMD_UNLK2  = 8'h55;
    localparam logic [7:0]  CMD_RESET  = 8'hf0;
    localparam logic [7:0]  CMD_PROG   = 8'ha0;
    localparam logic [7:0]  CMD_ERASE1 = 8'h80;
    localparam logic [7:0]  CMD_ERASE2 = 8'h10;
    localparam logic [7:0]  RESET_HI_A = 8'hff;
    localparam logic [7:0]  RESET_HI_B = 8'hfe;
    // Timing in machine-clock cycles, and status register reset value
    localparam int RDY_DELAY_CYC = 2;
    localparam int PROG_CYC      = 64;
    localparam int ERASE_CYC     = 512;
    localparam int TIMEOUT_CYC   = 1024;
    localparam logic [7:0] STATUS_RESET = 8'h10;

    typedef enum logic [1:0] {FPS_SZ_4K, FPS_SZ_8K, FPS_SZ_16K} fps_size_t;
endpackage

//--- hdl/fps_bus_if.sv
// CPU bus between the core and the flash interface.
// Assumes one clock; the core holds at most one access per cycle.
`timescale 1ns/1ns
interface fps_bus_if;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        rmw;
    logic [7:0]  rdata;
    logic        irq;

    modport dev (input addr, input wdata, input wr, input rd, input rmw,
                 output rdata, output irq);
    modport cpu (output addr, output wdata, output wr, output rd, output rmw,
                 input rdata, input irq);
endinterface

//--- hdl/fps_flash_dev.sv
// Flash interface: array, status register and command sequencer.
// Assumes the CPU end issues single-cycle rd/wr strobes on the same clock.
`timescale 1ns/1ns
module fps_flash_dev #(
    parameter int SIZE_KB   = 4,
    parameter int PROG_CYC  = fps_pkg::PROG_CYC,
    parameter int ERASE_CYC = fps_pkg::ERASE_CYC,
    parameter int TMO_CYC   = fps_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // CPU bus
    fps_bus_if.dev    bus,
    // Algorithm and sequencer-lock observation
    output logic      busy,
    output logic      lockedUp
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    localparam int DEPTH = SIZE_KB * 1024;
    localparam int AW    = $clog2(DEPTH);
    localparam logic [15:0] BASE = 16'(32'h10000 - DEPTH);

    typedef enum logic [2:0] {S_IDLE, S_C1, S_C2, S_PROG, S_E3, S_E4, S_E5, S_LOCK} fps_seq_t;
    typedef enum logic [1:0] {A_IDLE, A_ARM, A_PROG, A_ERASE} fps_alg_t;

    logic [7:0] mem [DEPTH];
    logic       inFlash;
    logic       cmdA;
    logic       cmd5;
    logic       hiMatch;
    logic       wrFlash;
    logic       oneReset;
    assign inFlash  = bus.addr >= BASE;
    assign cmdA     = bus.addr[11:0] == fps_pkg::CMD_ADDR_A;
    assign cmd5     = bus.addr[11:0] == fps_pkg::CMD_ADDR_5;
    assign wrFlash  = bus.wr && inFlash;
    assign oneReset = wrFlash && bus.wdata == fps_pkg::CMD_RESET
                      && (bus.addr[15:8] == fps_pkg::RESET_HI_A
                          || bus.addr[15:8] == fps_pkg::RESET_HI_B);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fps_seq_t    seq, next_seq;
    fps_alg_t    alg, next_alg;
    logic [3:0]  upper, next_upper;
    logic [15:0] cnt, next_cnt;
    logic [10:0] age, next_age;
    logic        doneFlag, next_doneFlag;
    logic        rdy, next_rdy;
    logic        done_irq_enable, next_done_irq_enable;
    logic        prog_erase_write_enable, next_wre;
    logic        tmo, next_tmo;
    logic        isErase, next_isErase;
    logic [AW-1:0] pAddr, next_pAddr;
    logic [7:0]  pData, next_pData;
    logic [7:0]  rdata, next_rdata;
    logic        irq, next_irq;
    logic        memWe;
    logic        algEnd;
    logic [7:0]  statusVal;

    assign hiMatch   = bus.addr[15:12] == upper;
    assign statusVal = {2'b00, (bus.rmw ? 1'b1 : doneFlag), rdy, 1'b0, done_irq_enable, prog_erase_write_enable, 1'b0};
    assign algEnd    = (alg == A_PROG || alg == A_ERASE) && cnt == 16'd0;

    always_comb begin
        next_seq = seq;
        next_alg = alg;
        next_upper = upper;
        next_cnt = cnt;
        next_age = age;
        next_doneFlag = doneFlag;
        next_rdy = rdy;
        next_done_irq_enable = done_irq_enable;
        next_wre = prog_erase_write_enable;
        next_tmo = tmo;
        next_isErase = isErase;
        next_pAddr = pAddr;
        next_pData = pData;
        next_rdata = 8'h00;
        memWe = 1'b0;
        // Status register writes; set beats clear below
        if (bus.wr && bus.addr == fps_pkg::STATUS_ADDR) begin
            next_done_irq_enable = bus.wdata[fps_pkg::BIT_DONE_IRQ_ENABLE];
            next_wre   = bus.wdata[fps_pkg::BIT_WRE];
            if (!bus.wdata[fps_pkg::BIT_DONE]) begin
                next_doneFlag = 1'b0;
            end
        end
        if (bus.rd) begin
            if (bus.addr == fps_pkg::STATUS_ADDR) begin
                next_rdata = statusVal;
            end else if (inFlash && alg != A_IDLE) begin
                next_rdata = 8'(tmo) << fps_pkg::BIT_TMO;
            end else if (inFlash) begin
                next_rdata = mem[bus.addr[AW-1:0]];
            end
        end
        // Algorithm engine
        case (alg)
            A_IDLE: ;
            A_ARM: begin
                // Second cycle after the command: ready drops
                next_rdy = 1'b0;
                next_alg = isErase ? A_ERASE : A_PROG;
                next_cnt = isErase ? 16'(ERASE_CYC) : 16'(PROG_CYC);
                next_age = '0;
            end
            A_PROG, A_ERASE: begin
                if (age != 11'(TMO_CYC)) begin
                    next_age = age + 11'd1;
                end else begin
                    next_tmo = 1'b1;
                end
                if (cnt != 16'd0) begin
                    next_cnt = cnt - 16'd1;
                end else begin
                    memWe         = (alg == A_PROG);
                    next_alg      = A_IDLE;
                    next_rdy      = 1'b1;
                    next_doneFlag = 1'b1;
                    next_seq      = S_IDLE;
                end
            end
            default: next_alg = A_IDLE;
        endcase
        // Command sequencer
        if (oneReset && alg != A_PROG) begin
            next_seq = S_IDLE;
            if (alg == A_ERASE) begin
                next_alg = A_IDLE;
                next_rdy = 1'b1;
            end
        end else if (wrFlash && alg != A_PROG && !algEnd) begin
            case (seq)
                S_IDLE: begin
                    next_seq = S_IDLE;
                    if (cmdA && bus.wdata == fps_pkg::CMD_UNLK1) begin
                        next_seq   = S_C1;
                        next_upper = bus.addr[15:12];
                    end
                end
                S_C1: next_seq = (cmd5 && hiMatch && bus.wdata == fps_pkg::CMD_UNLK2)
                                 ? S_C2 : S_IDLE;
                S_C2: begin
                    next_seq = S_IDLE;
                    if (cmdA && hiMatch && bus.wdata == fps_pkg::CMD_PROG && rdy) begin
                        next_seq = S_PROG;
                    end else if (cmdA && hiMatch && bus.wdata == fps_pkg::CMD_ERASE1 && rdy) begin
                        next_seq = S_E3;
                    end
                end
                S_PROG: begin
                    if (bus.addr[15:12] != upper) begin
                        next_seq = S_LOCK;
                    end else begin
                        next_seq = S_IDLE;
                        if (prog_erase_write_enable) begin
                            next_alg     = A_ARM;
                            next_isErase = 1'b0;
                            next_tmo     = 1'b0;
                            next_pAddr   = bus.addr[AW-1:0];
                            next_pData   = bus.wdata;
                        end
                    end
                end
                S_E3: next_seq = (cmdA && bus.wdata == fps_pkg::CMD_UNLK1) ? S_E4 : S_IDLE;
                S_E4: next_seq = (cmd5 && bus.wdata == fps_pkg::CMD_UNLK2) ? S_E5 : S_IDLE;
                S_E5: begin
                    next_seq = S_IDLE;
                    if (cmdA && bus.wdata == fps_pkg::CMD_ERASE2 && prog_erase_write_enable) begin
                        next_alg     = A_ARM;
                        next_isErase = 1'b1;
                        next_tmo     = 1'b0;
                    end
                end
                S_LOCK: next_seq = S_LOCK;
                default: next_seq = S_IDLE;
            endcase
        end
        // Four-cycle reset ends with a read after F0 to UAAA
        if (wrFlash && seq == S_C2 && cmdA && hiMatch && bus.wdata == fps_pkg::CMD_RESET) begin
            next_seq = S_IDLE;
        end
        next_irq = doneFlag && done_irq_enable;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seq      <= S_IDLE;
            alg      <= A_IDLE;
            upper    <= 4'h0;
            cnt      <= 16'd0;
            age      <= 11'd0;
            doneFlag <= 1'b0;
            rdy      <= 1'b1;
            done_irq_enable    <= 1'b0;
            prog_erase_write_enable      <= 1'b0;
            tmo      <= 1'b0;
            isErase  <= 1'b0;
            pAddr    <= '0;
            pData    <= 8'h00;
            rdata    <= 8'h00;
            irq      <= 1'b0;
            busy     <= 1'b0;
            lockedUp <= 1'b0;
        end else begin
            seq      <= next_seq;
            alg      <= next_alg;
            upper    <= next_upper;
            cnt      <= next_cnt;
            age      <= next_age;
            doneFlag <= next_doneFlag;
            rdy      <= next_rdy;
            done_irq_enable    <= next_done_irq_enable;
            prog_erase_write_enable      <= next_wre;
            tmo      <= next_tmo;
            isErase  <= next_isErase;
            pAddr    <= next_pAddr;
            pData    <= next_pData;
            rdata    <= next_rdata;
            irq      <= next_irq;
            busy     <= next_alg != A_IDLE;
            lockedUp <= next_seq == S_LOCK;
        end
    end

    // Array has no reset; programming can only clear bits, erase sets all ones
    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[pAddr] <= mem[pAddr] & pData;
        end else if (alg == A_ERASE && cnt == 16'd0) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'hff;
            end
        end
    end

    assign bus.rdata = rdata;
    assign bus.irq   = irq;
endmodule // fps_flash_dev

//--- hdl/fps_cpu_end.sv
// CPU-side end: turns user requests into flash command sequences.
// Assumes the device end on the same clock; runs its routine as if from RAM.
`timescale 1ns/1ns
module fps_cpu_end (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // User side
    input  wire logic [1:0]  reqOp,
    input  wire logic        reqValid,
    input  wire logic [15:0] reqAddr,
    input  wire logic [7:0]  reqData,
    output logic             reqDone,
    output logic [7:0]       rspData,
    // Bus
    fps_bus_if.cpu           bus
);
    // ------------------------------------------------------------------
    // Sequence walker
    // ------------------------------------------------------------------
    // reqOp: 0 read, 1 program, 2 erase, 3 read/reset
    typedef enum logic [2:0] {C_IDLE, C_SEQ, C_WAIT, C_POLL, C_RD, C_FIN} fps_cpu_t;
    fps_cpu_t    st, next_st;
    logic [2:0]  step, next_step;
    logic [1:0]  op, next_op;
    logic [15:0] tAddr, next_tAddr;
    logic [7:0]  tData, next_tData;
    logic [1:0]  gap, next_gap;
    logic [15:0] aN, next_aN;
    logic [7:0]  dN, next_dN;
    logic        wN, next_wN;
    logic        rN, next_rN;
    logic        doneN, next_doneN;
    logic [7:0]  rspN, next_rspN;
    logic [3:0]  u;
    logic [2:0]  lastStep;

    assign u = tAddr[15:12];
    assign lastStep = (op == 2'd2) ? 3'd6 : 3'd4;

    always_comb begin
        next_st = st;
        next_step = step;
        next_op = op;
        next_tAddr = tAddr;
        next_tData = tData;
        next_gap = gap;
        next_aN = 16'h0000;
        next_dN = 8'h00;
        next_wN = 1'b0;
        next_rN = 1'b0;
        next_doneN = 1'b0;
        next_rspN = rspN;
        case (st)
            C_IDLE: begin
                if (reqValid) begin
                    next_op = reqOp;
                    next_tAddr = reqAddr;
                    next_tData = reqData;
                    next_step = 3'd1;
                    next_st = (reqOp == 2'd0) ? C_RD : C_SEQ;
                    next_wN = reqOp[0] ^ reqOp[1];
                    next_aN = fps_pkg::STATUS_ADDR;
                    next_dN[fps_pkg::BIT_WRE] = 1'b1;
                end
            end
            C_SEQ: begin
                // Commands written back to back, upper nibble kept
                next_wN = 1'b1;
                case (step)
                    3'd1, 3'd4: begin
                        next_aN = {u, fps_pkg::CMD_ADDR_A};
                        next_dN = fps_pkg::CMD_UNLK1;
                    end
                    3'd2, 3'd5: begin
                        next_aN = {u, fps_pkg::CMD_ADDR_5};
                        next_dN = fps_pkg::CMD_UNLK2;
                    end
                    default: begin
                        next_aN = {u, fps_pkg::CMD_ADDR_A};
                        next_dN = fps_pkg::CMD_ERASE2;
                    end
                endcase
                if (step == 3'd3) begin
                    next_dN = (op == 2'd1) ? fps_pkg::CMD_PROG
                            : (op == 2'd2) ? fps_pkg::CMD_ERASE1 : fps_pkg::CMD_RESET;
                end
                if (step == 3'd4 && op == 2'd1) begin
                    next_aN = tAddr;
                    next_dN = tData;
                end
                if (step == 3'd4 && op == 2'd3) begin
                    next_wN = 1'b0;
                    next_st = C_RD;
                end else if (step == lastStep) begin
                    next_st = C_WAIT;
                    next_gap = 2'(fps_pkg::RDY_DELAY_CYC);
                end
                next_step = step + 3'd1;
            end
            C_WAIT: begin
                // No flash access while busy; wait before polling
                next_gap = gap - 2'd1;
                if (gap == 2'd1) begin
                    next_st = C_POLL;
                end
            end
            C_POLL: begin
                next_rN = 1'b1;
                next_aN = fps_pkg::STATUS_ADDR;
                if (rN && bus.rdata[fps_pkg::BIT_RDY]) begin
                    next_rN = 1'b0;
                    next_st = C_FIN;
                    next_rspN = bus.rdata;
                end
            end
            C_RD: begin
                next_rN = 1'b1;
                next_aN = tAddr;
                if (rN) begin
                    next_rN = 1'b0;
                    next_st = C_FIN;
                end
            end
            C_FIN: begin
                if (op == 2'd0 || op == 2'd3) begin
                    next_rspN = bus.rdata;
                end
                next_doneN = 1'b1;
                next_st = C_IDLE;
            end
            default: next_st = C_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st    <= C_IDLE;
            step  <= 3'd0;
            op    <= 2'd0;
            tAddr <= 16'h0000;
            tData <= 8'h00;
            gap   <= 2'd0;
            aN    <= 16'h0000;
            dN    <= 8'h00;
            wN    <= 1'b0;
            rN    <= 1'b0;
            doneN <= 1'b0;
            rspN  <= 8'h00;
        end else begin
            st    <= next_st;
            step  <= next_step;
            op    <= next_op;
            tAddr <= next_tAddr;
            tData <= next_tData;
            gap   <= next_gap;
            aN    <= next_aN;
            dN    <= next_dN;
            wN    <= next_wN;
            rN    <= next_rN;
            doneN <= next_doneN;
            rspN  <= next_rspN;
        end
    end

    // Reserved status bits are never written by this end
    assign bus.addr  = aN;
    assign bus.wdata = dN;
    assign bus.wr    = wN;
    assign bus.rd    = rN;
    assign bus.rmw   = 1'b0;
    assign reqDone   = doneN;
    assign rspData   = rspN;
endmodule // fps_cpu_end

//--- tb/fps_seq_asserts.sv
// Checker on the bus that joins the CPU end to the flash end.
// Assumes one clock; every input is the bus signal of the same name.
`timescale 1ns/1ns
module fps_seq_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // Bus
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic        rmw,
    input wire logic [7:0]  rdata,
    input wire logic        irq
);
    // ----------------------------------------
    // Last two command writes, {addr, data}
    // ----------------------------------------
    logic [23:0] prev1;
    logic [23:0] prev2;
    logic [23:0] next_prev1;
    logic [23:0] next_prev2;
    logic        cmdWr;
    logic        stRd;
    logic        flRd;
    assign cmdWr = wr && (addr != fps_pkg::STATUS_ADDR);
    assign stRd  = rd && (addr == fps_pkg::STATUS_ADDR);
    assign flRd  = rd && (addr >= fps_pkg::FLASH_BASE_16K);
    always_comb begin
        next_prev1 = cmdWr ? {addr, wdata} : prev1;
        next_prev2 = cmdWr ? prev1 : prev2;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev1 <= 24'h000000;
            prev2 <= 24'h000000;
        end else begin
            prev1 <= next_prev1;
            prev2 <= next_prev2;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_unlock2;
        cmdWr && wdata == fps_pkg::CMD_UNLK2 && addr[11:0] == fps_pkg::CMD_ADDR_5;
    endsequence
    sequence s_prog_cmd;
        cmdWr && wdata == fps_pkg::CMD_PROG && addr[11:0] == fps_pkg::CMD_ADDR_A;
    endsequence
    sequence s_prog_data;
        cmdWr && prev1[7:0] == fps_pkg::CMD_PROG && prev1[19:8] == fps_pkg::CMD_ADDR_A
            && prev2[7:0] == fps_pkg::CMD_UNLK2;
    endsequence
    a_unlock_order: assert property (s_unlock2 |-> prev1[7:0] == fps_pkg::CMD_UNLK1
        && prev1[19:8] == fps_pkg::CMD_ADDR_A) else $error("unlock out of order");
    a_prog_order: assert property (s_prog_cmd |-> prev1[7:0] == fps_pkg::CMD_UNLK2)
        else $error("program code out of order");
    a_prog_nibble: assert property (s_prog_data |-> addr[15:12] == prev1[23:20]
        && addr >= fps_pkg::FLASH_BASE_16K) else $error("program nibble differs");
    a_erase_order: assert property (cmdWr && wdata == fps_pkg::CMD_ERASE2
        && addr[11:0] == fps_pkg::CMD_ADDR_A && prev1[7:0] != fps_pkg::CMD_PROG
        |-> prev1[7:0] == fps_pkg::CMD_UNLK2 && prev2[7:0] == fps_pkg::CMD_UNLK1)
        else $error("erase out of order");
    a_poll_wait: assert property (s_prog_data |=> !stRd [*2])
        else $error("status polled too early");
    a_no_flash_read: assert property (s_prog_data |=> !flRd [*4])
        else $error("flash read during programming");
    a_reserved_zero: assert property (wr && addr == fps_pkg::STATUS_ADDR
        |-> !wdata[3] && !wdata[0]) else $error("reserved bit written one");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_status_top_zero: assert property ($past(stRd) |-> (rdata & 8'hc9) == 8'h00)
        else $error("undefined status bit nonzero");
    a_rmw_done_one: assert property ($past(stRd) && $past(rmw) |-> rdata[5])
        else $error("rmw read of done not one");
    a_irq_matches: assert property ($past(stRd) && !$past(rmw)
        |-> irq == (rdata[5] && rdata[2])) else $error("irq differs from flag and enable");
endmodule // fps_seq_asserts

//--- tb/test_flash_program_erase_sequencer.sv
// Bench: both ends joined, plus a bare flash end driven from here.
// Assumes the shortened algorithm counts set at the instances below.
`timescale 1ns/1ns
module test_flash_program_erase_sequencer;
    typedef struct packed {
        logic [1:0]  op;
        logic [15:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
        logic        c;
    } fps_row_t;
    logic        clk      = 1'b0;
    logic        rst_b    = 1'b0;
    logic [1:0]  reqOp    = 2'h0;
    logic        reqValid = 1'b0;
    logic [15:0] reqAddr  = 16'h0000;
    logic [7:0]  reqData  = 8'h00;
    logic        reqDone, busy1, lock1, busy2, lock2;
    logic [7:0]  rspData;
    int          err_count   = 0;
    int          comparisons = 0;
    fps_row_t    rows [8];
    fps_bus_if bus1 ();
    fps_bus_if bus2 ();
    always #5 clk = ~clk;
    fps_cpu_end fps_cpu_end_i (.clk(clk), .rst_b(rst_b), .reqOp(reqOp), .reqValid(reqValid),
        .reqAddr(reqAddr), .reqData(reqData), .reqDone(reqDone), .rspData(rspData), .bus(bus1));
    fps_flash_dev #(.PROG_CYC(4), .ERASE_CYC(8)) fps_flash_dev_i (.clk(clk),
        .rst_b(rst_b), .bus(bus1), .busy(busy1), .lockedUp(lock1));
    // Second flash end, 16 KB, for broken command rules
    fps_flash_dev #(.PROG_CYC(4), .ERASE_CYC(8), .SIZE_KB(16)) fps_flash_dev_i2 (.clk(clk),
        .rst_b(rst_b), .bus(bus2), .busy(busy2), .lockedUp(lock2));
    fps_seq_asserts fps_seq_asserts_i (.clk(clk), .rst_b(rst_b), .addr(bus1.addr),
        .wdata(bus1.wdata), .wr(bus1.wr), .rd(bus1.rd), .rmw(bus1.rmw), .rdata(bus1.rdata),
        .irq(bus1.irq));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr2(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus2.wr <= 1'b1;
        bus2.addr <= a;
        bus2.wdata <= d;
    endtask
    task automatic seq(input logic [3:0] u, input logic [7:0] c);
        wr2({u, 12'haaa}, 8'haa);
        wr2({u, 12'h554}, 8'h55);
        wr2({u, 12'haaa}, c);
    endtask
    task automatic idle2(input int n);
        repeat (n) begin
            @(posedge clk);
            bus2.wr <= 1'b0;
        end
        #1;
    endtask
    task automatic chk(input logic [15:0] a, input logic m, input logic [7:0] k,
                       input logic [7:0] e);
        @(posedge clk);
        bus2.wr <= 1'b0;
        bus2.rd <= 1'b1;
        bus2.rmw <= m;
        bus2.addr <= a;
        @(posedge clk);
        bus2.rd <= 1'b0;
        bus2.rmw <= 1'b0;
        #1;
        check(bus2.rdata & k, e);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy2 !== 1'b0 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h00, busy2}, 8'h00);
    endtask
    task automatic req(input fps_row_t r);
        int n;
        n = 0;
        @(posedge clk);
        reqOp <= r.op;
        reqAddr <= r.a;
        reqData <= r.d;
        reqValid <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        #1;
        while (reqDone !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (r.c) check(rspData, r.e);
        if (n >= 3000) err_count++;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        bus2.addr = 16'h0000;
        bus2.wdata = 8'h00;
        bus2.wr = 1'b0;
        bus2.rd = 1'b0;
        bus2.rmw = 1'b0;
        rows = '{'{2'd2, 16'hf000, 8'h00, 8'h00, 1'b0}, '{2'd0, 16'hf010, 8'h00, 8'hff, 1'b1},
                 '{2'd1, 16'hf010, 8'h5a, 8'h00, 1'b0}, '{2'd0, 16'hf010, 8'h00, 8'h5a, 1'b1},
                 '{2'd1, 16'hf123, 8'ha5, 8'h00, 1'b0}, '{2'd0, 16'hf123, 8'h00, 8'ha5, 1'b1},
                 '{2'd3, 16'hff00, 8'h00, 8'h00, 1'b0}, '{2'd0, 16'hf010, 8'h00, 8'h5a, 1'b1}};
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) req(rows[i]);
        chk(16'h0072, 1'b0, 8'hff, 8'h10);
        check({7'h00, bus2.irq}, 8'h00);
        wr2(16'h0072, 8'he6);
        seq(4'hf, 8'h80);
        seq(4'hf, 8'h10);
        idle2(12);
        wr2(16'h0072, 8'hc6);
        chk(16'h0072, 1'b0, 8'hff, 8'h16);
        seq(4'hf, 8'ha0);
        wr2(16'hf020, 8'h5a);
        idle2(2);
        chk(16'h0072, 1'b0, 8'hff, 8'h06);
        chk(16'hf020, 1'b0, 8'h20, 8'h00);
        wait_idle();
        chk(16'h0072, 1'b0, 8'hff, 8'h36);
        check({7'h00, bus2.irq}, 8'h01);
        chk(16'hf020, 1'b0, 8'hff, 8'h5a);
        wr2(16'h0072, 8'h06);
        chk(16'h0072, 1'b0, 8'hff, 8'h16);
        check({7'h00, bus2.irq}, 8'h00);
        chk(16'h0072, 1'b1, 8'hff, 8'h36);
        // Erase, interrupt off; program meanwhile is refused
        wr2(16'h0072, 8'h02);
        seq(4'hc, 8'h80);
        seq(4'hc, 8'h10);
        idle2(2);
        chk(16'h0072, 1'b0, 8'hff, 8'h02);
        seq(4'hf, 8'ha0);
        wr2(16'hf050, 8'h00);
        idle2(1);
        wait_idle();
        chk(16'h0072, 1'b0, 8'hff, 8'h32);
        check({7'h00, bus2.irq}, 8'h00);
        chk(16'hf020, 1'b0, 8'hff, 8'hff);
        chk(16'hf050, 1'b0, 8'hff, 8'hff);
        wr2(16'h0072, 8'h00);
        seq(4'hf, 8'ha0);
        wr2(16'hf060, 8'h00);
        idle2(2);
        chk(16'h0072, 1'b0, 8'hff, 8'h10);
        chk(16'hf060, 1'b0, 8'hff, 8'hff);
        // Nibble mismatch locks until a reset write
        wr2(16'h0072, 8'h02);
        seq(4'he, 8'ha0);
        wr2(16'hf070, 8'h00);
        idle2(1);
        check({7'h00, lock2}, 8'h01);
        wr2(16'hff00, 8'hf0);
        idle2(2);
        check({7'h00, lock2}, 8'h00);
        chk(16'hf070, 1'b0, 8'hff, 8'hff);
        wr2(16'hfaaa, 8'haa);
        wr2(16'hf554, 8'h33);
        wr2(16'hfaaa, 8'ha0);
        wr2(16'hf080, 8'h00);
        idle2(2);
        chk(16'h0072, 1'b0, 8'hff, 8'h12);
        chk(16'hf080, 1'b0, 8'hff, 8'hff);
        seq(4'hf, 8'hf0);
        chk(16'hf020, 1'b0, 8'hff, 8'hff);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk(16'h0072, 1'b0, 8'hff, 8'h10);
        test_done();
    end
    // Watchdog, ample margin
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule // test_flash_program_erase_sequencer
